//--- design/bus_ctrl_consts.vh
`ifndef BUS_CTRL_CONSTS_VH
`define BUS_CTRL_CONSTS_VH
`define RESET_VECTOR 32'h00000000
`define ADDR_STEP 32'h00000004
`define TEST_IN_W 17
`define TEST_OUT_W 3
`define MIN_RESET_FAST 4'h2
`define MIN_RESET_MEM 4'h5
`define CNT_W 4
`define CNT_ONE 4'h1
`define CNT_ZERO 4'h0
`define SYNC_W 9
`define SYNC_INIT 9'h03f
`endif

//--- design/sync2.v
module sync2 #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b1}}
)
(
    input wire clk,
    input wire rst,
    input wire ce,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta;
    always @(posedge clk)
    begin
        if (rst)
        begin
            meta <= INIT;
            q <= INIT;
        end
        else if (ce)
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

//--- design/cpu_external_bus_control.v
`include "bus_ctrl_consts.vh"
// How it works
// - request enable low floats request outputs
// - size high for word, low byte
// - size valid both ways, latched phase
// - fast interrupt level taken when enabled
// - normal interrupt same, lower priority
// - request pipelined, changes during clock low
// - reset aborts, disables caches
// - after reset fetch from address zero
// - idle incrementing cycles during reset
// - direction high write, latched phase
// - stall low extends current access
// - linear flag inverts memory request
// - test outputs low when tests low
// - test port timed by test clock
// - latch control low holds latched outputs
// - core clock fast, memory uses bus clock
module cpu_external_bus_control #(
    parameter AW = 32
)
(
    input wire clk,
    input wire rst,
    input wire ce,
    input wire memory_clock,
    input wire core_fast_clock,
    input wire core_reset_low,
    input wire test_port_reset_low,
    input wire request_output_enable,
    input wire address_latch_enable,
    input wire stall_request_low,
    input wire fast_interrupt_low,
    input wire normal_interrupt_low,
    input wire fast_interrupt_enable,
    input wire normal_interrupt_enable,
    input wire interrupt_ack,
    input wire strap_high_input,
    input wire [`TEST_IN_W-1:0] factory_test_inputs,
    input wire core_req,
    input wire core_write,
    input wire core_word,
    input wire [AW-1:0] core_addr,
    output reg memory_cycle_request_low,
    output reg memory_cycle_request_low_oe,
    output reg linear_access_flag,
    output reg linear_access_flag_oe,
    output reg word_not_byte,
    output reg write_not_read,
    output reg [AW-1:0] address,
    output reg core_stalled,
    output reg caches_enabled,
    output reg core_in_reset,
    output reg core_on_fast_clock,
    output reg take_fast_interrupt,
    output reg take_normal_interrupt,
    output reg [`TEST_OUT_W-1:0] factory_test_outputs,
    output reg factory_test_outputs_oe
);
    localparam ST_RESET = 3'b001;
    localparam ST_IDLE = 3'b010;
    localparam ST_MEM = 3'b100;

    wire [`SYNC_W-1:0] s;
    // one sync bank for the nine control pins; first stage read only inside sync2
    // init matches idle pin levels so no false edge follows reset
    sync2 #(.W(`SYNC_W), .INIT(`SYNC_INIT)) u_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .d({memory_clock, core_fast_clock, core_reset_low,
            test_port_reset_low, request_output_enable,
            address_latch_enable, stall_request_low,
            fast_interrupt_low, normal_interrupt_low}),
        .q(s)
    );
    wire mclk_s = s[8];
    wire core_fast_clock_s = s[7];
    wire core_reset_low_s = s[6];
    wire trst_s = s[5];
    wire mse_s = s[4];
    wire ale_s = s[3];
    wire stall_request_low_s = s[2];
    wire fast_interrupt_low_s = s[1];
    wire normal_interrupt_low_s = s[0];
    wire tests_low = ~|factory_test_inputs;

    reg [2:0] state;
    reg [2:0] next_state;
    reg mclk_d;
    reg core_fast_clock_d;
    reg [`CNT_W-1:0] mcnt;
    reg [`CNT_W-1:0] fcnt;
    reg trst_seen;
    reg req_pipe;
    reg [AW-1:0] idle_addr;
    reg word_int;
    reg write_int;
    reg [AW-1:0] addr_int;
    reg fiq_pend;
    reg irq_pend;

    wire mclk_rise = mclk_s & ~mclk_d;
    wire mclk_fall = ~mclk_s & mclk_d;
    wire core_fast_clock_rise = core_fast_clock_s & ~core_fast_clock_d;
    wire reset_long = (mcnt >= `MIN_RESET_MEM) && (fcnt >= `MIN_RESET_FAST);

    always @*
    begin
        next_state = state;
        case (state)
            ST_RESET:
                if (core_reset_low_s && reset_long && trst_seen)
                    next_state = ST_IDLE;
            ST_IDLE:
                if (!core_reset_low_s)
                    next_state = ST_RESET;
                else if (mclk_fall && core_req)
                    next_state = ST_MEM;
            ST_MEM:
                if (!core_reset_low_s)
                    next_state = ST_RESET;
                // stall held low keeps the access open
                else if (mclk_fall && stall_request_low_s && !core_req)
                    next_state = ST_IDLE;
            default:
                next_state = ST_RESET;
        endcase
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            state <= ST_RESET;
            mclk_d <= 1'b0;
            core_fast_clock_d <= 1'b0;
            mcnt <= `CNT_ZERO;
            fcnt <= `CNT_ZERO;
            trst_seen <= 1'b0;
            req_pipe <= 1'b1;
            idle_addr <= `RESET_VECTOR;
            word_int <= 1'b1;
            write_int <= 1'b0;
            addr_int <= `RESET_VECTOR;
            caches_enabled <= 1'b0;
            core_in_reset <= 1'b1;
        end
        else if (ce)
        begin
            state <= next_state;
            mclk_d <= mclk_s;
            core_fast_clock_d <= core_fast_clock_s;
            // reset width counted on both clocks; saturates
            if (core_reset_low_s)
            begin
                mcnt <= `CNT_ZERO;
                fcnt <= `CNT_ZERO;
            end
            else
            begin
                if (mclk_rise && mcnt != `MIN_RESET_MEM)
                    mcnt <= mcnt + `CNT_ONE;
                if (core_fast_clock_rise && fcnt != `MIN_RESET_FAST)
                    fcnt <= fcnt + `CNT_ONE;
            end
            if (!trst_s)
                trst_seen <= 1'b1;
            if (state == ST_RESET)
            begin
                caches_enabled <= 1'b0;
                core_in_reset <= 1'b1;
                write_int <= 1'b0;
                word_int <= 1'b1;
                req_pipe <= 1'b1;
                // idle cycles walk the address; stall must stay high
                if (mclk_rise)
                    idle_addr <= idle_addr + `ADDR_STEP;
                addr_int <= idle_addr;
                if (next_state == ST_IDLE)
                begin
                    addr_int <= `RESET_VECTOR;
                    idle_addr <= `RESET_VECTOR;
                end
            end
            else
            begin
                core_in_reset <= 1'b0;
                caches_enabled <= 1'b1;
                // request is decided for the next cycle during low phase
                if (mclk_fall)
                    req_pipe <= ~core_req;
                if (mclk_fall && core_req)
                begin
                    word_int <= core_word;
                    write_int <= core_write;
                    addr_int <= core_addr;
                end
            end
        end
    end

    // in_reset decoding shared by the interrupt and pin-side blocks; latch_open used pin-side only
    function in_reset;
        input [2:0] st;
        begin
            in_reset = (st == ST_RESET);
        end
    endfunction

    function latch_open;
        input hi;
        input le;
        begin
            latch_open = hi & le;
        end
    endfunction

    always @(posedge clk)
    begin
        if (rst)
        begin
            fiq_pend <= 1'b0;
            irq_pend <= 1'b0;
            take_fast_interrupt <= 1'b0;
            take_normal_interrupt <= 1'b0;
            core_stalled <= 1'b0;
            core_on_fast_clock <= 1'b1;
        end
        else if (ce)
        begin
            core_stalled <= (state == ST_MEM) && !stall_request_low_s;
            // core on fast clock unless on external memory
            core_on_fast_clock <= (state != ST_MEM);
            // level inputs, no latching beyond the ack
            fiq_pend <= !fast_interrupt_low_s && fast_interrupt_enable && !interrupt_ack
                && !in_reset(state);
            irq_pend <= !normal_interrupt_low_s && normal_interrupt_enable && !interrupt_ack
                && !in_reset(state);
            take_fast_interrupt <= fiq_pend;
            take_normal_interrupt <= irq_pend && !fiq_pend;
        end
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            memory_cycle_request_low <= 1'b1;
            memory_cycle_request_low_oe <= 1'b0;
            linear_access_flag <= 1'b0;
            linear_access_flag_oe <= 1'b0;
            word_not_byte <= 1'b1;
            write_not_read <= 1'b0;
            address <= `RESET_VECTOR;
            factory_test_outputs <= {`TEST_OUT_W{1'b0}};
            factory_test_outputs_oe <= 1'b1;
        end
        else if (ce)
        begin
            // reset state forces the idle level without waiting a cycle
            if (!mclk_s)
            begin
                memory_cycle_request_low <= req_pipe | in_reset(state);
                linear_access_flag <= ~(req_pipe | in_reset(state));
            end
            memory_cycle_request_low_oe <= mse_s;
            linear_access_flag_oe <= mse_s;
            // latched outputs move in the high phase; latch low holds
            if (latch_open(mclk_s, ale_s))
            begin
                word_not_byte <= word_int;
                write_not_read <= write_int;
                address <= addr_int;
            end
            factory_test_outputs <= {`TEST_OUT_W{1'b0}};
            // scan port has its own test clock; not part of this block
            factory_test_outputs_oe <= tests_low | ~strap_high_input;
        end
    end
endmodule

//--- tb/bus_ctrl_chk_sva.sv
module bus_ctrl_chk (
    input wire logic clk, rst, memory_clock, core_in_reset,
    input wire logic caches_enabled, request_output_enable,
    input wire logic memory_cycle_request_low, memory_cycle_request_low_oe,
    input wire logic linear_access_flag, linear_access_flag_oe,
    input wire logic word_not_byte, write_not_read, core_stalled,
    input wire logic [16:0] factory_test_inputs,
    input wire logic [2:0] factory_test_outputs,
    input wire logic factory_test_outputs_oe, stall_request_low,
    input wire logic fast_interrupt_low, fast_interrupt_enable,
    input wire logic interrupt_ack, take_fast_interrupt
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // pin clock passes two sync stages and the output register, so look back three cycles
    sequence fast_held;
        (!fast_interrupt_low && fast_interrupt_enable && !interrupt_ack
            && !core_in_reset) [*6];
    endsequence
    chk_flag_inverse: assert property (
        linear_access_flag != memory_cycle_request_low)
        else $error("flag not inverse of request");
    chk_request_float: assert property (
        !request_output_enable [*4] |->
        !memory_cycle_request_low_oe && !linear_access_flag_oe)
        else $error("request outputs still driven");
    chk_test_out_low: assert property (
        factory_test_inputs == 17'h00000 [*2] |->
        factory_test_outputs == 3'h0 && factory_test_outputs_oe)
        else $error("test outputs not low");
    chk_reset_quiet: assert property (
        core_in_reset |-> memory_cycle_request_low && !caches_enabled)
        else $error("activity in core reset");
    chk_request_phase: assert property (
        $changed(memory_cycle_request_low) |-> !$past(memory_clock, 3))
        else $error("request moved in clock high");
    chk_dir_phase: assert property (
        $changed(write_not_read) |-> $past(memory_clock, 3))
        else $error("direction moved in clock low");
    chk_size_phase: assert property (
        $changed(word_not_byte) |-> $past(memory_clock, 3))
        else $error("size moved in clock low");
    chk_fast_taken: assert property (
        fast_held |-> take_fast_interrupt)
        else $error("fast interrupt not taken");
    chk_stall_holds: assert property (
        core_stalled && !stall_request_low |=> core_stalled)
        else $error("stall released early");
endmodule

bind cpu_external_bus_control bus_ctrl_chk bus_ctrl_chk_i (.*);

//--- tb/mem_partner.sv
module mem_partner (
    input wire logic clk,
    input wire logic hold_reset,
    input wire logic want_stall,
    output logic memory_clock,
    output logic stall_request_low
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] n = 3'h0;
    initial memory_clock = 1'b0;
    initial stall_request_low = 1'b1;
    always @(posedge clk)
    begin
        n <= n + 3'h1;
        if (n == 3'h7)
            memory_clock <= ~memory_clock;
        if (!memory_clock && n != 3'h7)
            stall_request_low <= hold_reset | ~want_stall;
    end
endmodule

//--- tb/cpu_external_bus_control_test.sv
module cpu_external_bus_control_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, core_fast_clock = 1'b0;
    logic memory_clock, stall_request_low, want_stall = 1'b0;
    logic core_reset_low = 1'b0, test_port_reset_low = 1'b0;
    logic request_output_enable = 1'b1, address_latch_enable = 1'b1;
    logic fast_interrupt_low = 1'b1, normal_interrupt_low = 1'b1;
    logic fast_interrupt_enable = 1'b0, normal_interrupt_enable = 1'b0;
    logic interrupt_ack = 1'b0, strap_high_input = 1'b1;
    logic [16:0] factory_test_inputs = 17'h00000;
    logic core_req = 1'b0, core_write = 1'b0, core_word = 1'b0;
    logic [31:0] core_addr = 32'h00000000, address, a0;
    logic memory_cycle_request_low, memory_cycle_request_low_oe;
    logic linear_access_flag, linear_access_flag_oe, word_not_byte;
    logic write_not_read, core_stalled, caches_enabled, core_in_reset;
    logic core_on_fast_clock, take_fast_interrupt, take_normal_interrupt;
    logic [2:0] factory_test_outputs;
    logic factory_test_outputs_oe;
    int bad_count = 0, checks = 0, i;
    cpu_external_bus_control cpu_external_bus_control_i (.*);
    mem_partner mem_partner_i (.clk(clk), .hold_reset(!core_reset_low),
        .want_stall(want_stall), .memory_clock(memory_clock),
        .stall_request_low(stall_request_low));
    always #4 clk = ~clk;
    // offset keeps fast clock edges off the system clock edges
    initial
    begin
        #2;
        forever #12 core_fast_clock = ~core_fast_clock;
    end
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task check(input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task t_reset;
        step(20);
        check(core_in_reset, 1'b1);
        check(caches_enabled, 1'b0);
        check({factory_test_outputs_oe, factory_test_outputs}, 4'h8);
        factory_test_inputs = 17'h00001;
        step(2);
        check(factory_test_outputs_oe, 1'b0);
        factory_test_inputs = 17'h00000;
        step(2);
        check(factory_test_outputs_oe, 1'b1);
        test_port_reset_low = 1'b1;
        @(posedge memory_clock);
        step(5);
        a0 = address;
        @(posedge memory_clock);
        step(5);
        check(address, a0 + 32'h00000004);
        step(90);
        core_reset_low = 1'b1;
        for (i = 0; i < 100 && core_in_reset !== 1'b0; i++) step(1);
        @(posedge memory_clock);
        step(5);
        check(address, 32'h00000000);
        $display("reset test done");
    endtask
    task t_access;
        for (int k = 0; k < 4; k++)
        begin
            core_write = k[0];
            core_word = k[1];
            core_addr = 32'h00000100 + 32'(k * 4);
            core_req = 1'b1;
            for (i = 0; i < 60 && memory_cycle_request_low !== 1'b0; i++)
                step(1);
            check(linear_access_flag, 1'b1);
            @(posedge memory_clock);
            step(5);
            check(write_not_read, core_write);
            check(word_not_byte, core_word);
            check(address, core_addr);
            core_req = 1'b0;
            step(20);
        end
        address_latch_enable = 1'b0;
        core_addr = 32'h00000200;
        core_req = 1'b1;
        for (i = 0; i < 60 && memory_cycle_request_low !== 1'b0; i++)
            step(1);
        @(posedge memory_clock);
        step(5);
        check(address, 32'h0000010c);
        core_req = 1'b0;
        address_latch_enable = 1'b1;
        core_addr = 32'h0000010c;
        step(20);
        $display("access test done");
    endtask
    task t_stall;
        want_stall = 1'b1;
        core_req = 1'b1;
        for (i = 0; i < 100 && core_stalled !== 1'b1; i++) step(1);
        step(40);
        check(core_stalled, 1'b1);
        core_req = 1'b0;
        want_stall = 1'b0;
        for (i = 0; i < 100 && core_stalled !== 1'b0; i++) step(1);
        check(core_stalled, 1'b0);
        request_output_enable = 1'b0;
        step(5);
        check(memory_cycle_request_low_oe | linear_access_flag_oe, 1'b0);
        request_output_enable = 1'b1;
        step(3);
        check(memory_cycle_request_low_oe, 1'b1);
        $display("stall and float test done");
    endtask
    task t_irq(input logic f);
        fast_interrupt_low = !f;
        normal_interrupt_low = f;
        step(10);
        check(take_fast_interrupt | take_normal_interrupt, 1'b0);
        fast_interrupt_enable = f;
        normal_interrupt_enable = !f;
        step(10);
        check(take_fast_interrupt, f);
        check(take_normal_interrupt, !f);
        interrupt_ack = 1'b1;
        fast_interrupt_low = 1'b1;
        normal_interrupt_low = 1'b1;
        step(4);
        interrupt_ack = 1'b0;
        step(2);
        check(take_fast_interrupt | take_normal_interrupt, 1'b0);
        $display("interrupt test done");
    endtask
    initial
    begin
        step(10);
        rst = 1'b0;
        t_reset;
        t_access;
        t_stall;
        t_irq(1'b1);
        t_irq(1'b0);
        give_verdict;
    end
    initial
    begin
        step(20000);
        bad_count++;
        give_verdict;
    end
endmodule
